// File: common/isa_pkg.sv
// constants and types for the primary requester address/data path
package isa_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_TIME_NS = 300;
    localparam int XFER_TIME_NS = 500;
    localparam int STROBE_CLKS = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XFER_CLKS = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int MEM_ADDR_BITS = 24;
    localparam int IO_ADDR_BITS = 16;
    localparam int LATCHED_BITS = 20;
    localparam int UPPER_LSB = 17;
    localparam int UPPER_BITS = MEM_ADDR_BITS - UPPER_LSB;
    localparam int DATA_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int ROW_BITS = 8;
    localparam int MAX_AGENTS = 5;
    localparam int MAX_FAR_AGENTS = MAX_AGENTS - 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [LATCHED_BITS-1:0] SYNC_RESET = 20'hF0000;
    localparam logic [ROW_BITS-1:0] ROW_RESET = 8'h00;

    typedef enum logic [1:0] {KIND_MEM, KIND_IO, KIND_DMA, KIND_REFRESH} cycle_kind_e;
    typedef enum logic [1:0] {OWN_CPU, OWN_DMA, OWN_SECONDARY} bus_owner_e;

endpackage

// File: common/isa_steer_if.sv
// signals between the cycle sequencer and the byte steering logic
`timescale 1ns/10ps
interface isa_steer_if;
    logic odd;
    logic word;
    logic narrow;
    logic second;
    logic [isa_pkg::DATA_BITS-1:0] wdata;
    logic [isa_pkg::DATA_BITS-1:0] pin_din;
    logic [isa_pkg::DATA_BITS-1:0] pin_dout;
    logic high_en_n;
    logic [isa_pkg::BYTE_BITS-1:0] rd_byte;

    modport ctrl (
        output odd, word, narrow, second, wdata, pin_din,
        input pin_dout, high_en_n, rd_byte
    );
    modport steer (
        input odd, word, narrow, second, wdata, pin_din,
        output pin_dout, high_en_n, rd_byte
    );
endinterface

// File: hdl/isa_byte_steer.sv
// byte lane steering between a 16-bit requester and 8- or 16-bit repliers
`timescale 1ns/10ps
module isa_byte_steer (
    // steering controls and lanes
    isa_steer_if.steer st
);
    // ------------------------------------------------------------
    // lane selection
    // ------------------------------------------------------------
    wire odd_lane = st.odd | st.second;
    wire wide_word = st.word & ~st.narrow;
    wire [7:0] wr_byte = odd_lane ? st.wdata[15:8] : st.wdata[7:0];
    wire [15:0] byte_lanes_wide = odd_lane ? {wr_byte, 8'h00} : {8'h00, wr_byte};
    // narrow replier sits on the low lanes only; odd byte copied upward
    wire [15:0] byte_lanes_narrow = odd_lane ? {wr_byte, wr_byte} : {8'h00, wr_byte}; // [R20] [R19]

    assign st.pin_dout = wide_word ? st.wdata : (st.narrow ? byte_lanes_narrow : byte_lanes_wide);
    // high lanes carry data on odd bytes and full words
    assign st.high_en_n = ~(odd_lane | wide_word); // [R12]
    assign st.rd_byte = (st.narrow || !odd_lane) ? st.pin_din[7:0] : st.pin_din[15:8];

endmodule // isa_byte_steer

// File: hdl/isa_primary_agent.sv
// address and data path of the primary requester on a 16-bit expansion bus
//
// Rules of the document for this bus
// R01 - secondary requesters must have 16-bit interfaces
// R02 - replying agents never start a cycle
// R03 - at most five agents, one primary
// R04 - memory 24 address bits, I/O 16
// R05 - primary refreshes, also for owning secondary
// R06 - latched low 20 bits valid with strobe
// R07 - I/O cycles drive latched bits 19:16 low
// R08 - refresh drives row, all other address zero
// R09 - upper unlatched address driven, zero for I/O
// R10 - secondary holds upper address, primary strobes
// R11 - 16-bit repliers decode upper address lines
// R12 - high byte enable marks upper lane data
// R13 - primary drives strobe, latches own address
// R14 - agents treat strobe as level sensitive
// R15 - strobe asserted on every DMA cycle
// R16 - DMA address enable only when DMA owns
// R17 - others float address when enable asserted
// R18 - DMA address valid with enable and strobe
// R19 - 8-bit repliers use low data lanes
// R20 - odd byte to 8-bit copied onto high
// R21 - word to 8-bit splits into two cycles
// R22 - data lines floated during refresh
`timescale 1ns/10ps
module isa_primary_agent #(
    parameter int AGENT_SLOTS = isa_pkg::MAX_FAR_AGENTS
) (
    // clock, enable and reset
    input logic core_clk_in,
    input logic ce_in,
    input logic reset_in,
    // local request port
    input logic req_valid_in,
    output logic req_ready_out,
    input isa_pkg::cycle_kind_e req_kind_in,
    input logic [isa_pkg::MEM_ADDR_BITS-1:0] req_addr_in,
    input logic req_word_in,
    input logic req_write_in,
    input logic [isa_pkg::DATA_BITS-1:0] req_wdata_in,
    output logic resp_valid_out,
    output logic [isa_pkg::DATA_BITS-1:0] resp_rdata_out,
    // bus ownership from the local arbiter
    input isa_pkg::bus_owner_e owner_in,
    // address group pins
    output logic [isa_pkg::LATCHED_BITS-1:0] latched_address_out,
    output logic latched_address_oe_out,
    output logic [isa_pkg::UPPER_BITS-1:0] unlatched_upper_address_out,
    output logic unlatched_upper_address_oe_out,
    output logic address_latch_strobe_out,
    output logic dma_address_enable_out,
    output logic high_byte_enable_n_out,
    output logic high_byte_enable_oe_out,
    // data group pins
    input logic [isa_pkg::DATA_BITS-1:0] data_in,
    output logic [isa_pkg::DATA_BITS-1:0] data_out,
    output logic data_oe_out,
    // width selects and secondary requester pins
    input logic wide_memory_select_n_in,
    input logic wide_io_select_n_in,
    input logic secondary_cycle_n_in,
    input logic secondary_refresh_n_in
);

    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_XFER} seq_state_e;

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    function automatic logic [isa_pkg::MEM_ADDR_BITS-1:0] form_address(
        input isa_pkg::cycle_kind_e k,
        input logic [isa_pkg::MEM_ADDR_BITS-1:0] a,
        input logic [isa_pkg::ROW_BITS-1:0] r
    );
        logic [isa_pkg::MEM_ADDR_BITS-1:0] f;
        f = a; // [R04]
        if (k == isa_pkg::KIND_IO) begin
            f = {8'h00, a[isa_pkg::IO_ADDR_BITS-1:0]}; // [R04] [R07] [R09]
        end else if (k == isa_pkg::KIND_REFRESH) begin
            f = {16'h0000, r}; // [R08]
        end
        return f;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [isa_pkg::LATCHED_BITS-1:0] sync_meta;
    logic [isa_pkg::LATCHED_BITS-1:0] sync_stage;
    logic [1:0] sec_prev;
    wire [isa_pkg::LATCHED_BITS-1:0] pin_raw = {secondary_refresh_n_in, secondary_cycle_n_in,
                                                wide_io_select_n_in, wide_memory_select_n_in, data_in};

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sync_meta <= isa_pkg::SYNC_RESET;
            sync_stage <= isa_pkg::SYNC_RESET;
            sec_prev <= 2'h3;
        end else if (ce_in) begin
            sync_meta <= pin_raw;
            sync_stage <= sync_meta;
            sec_prev <= sync_stage[19:18];
        end
    end

    wire [isa_pkg::DATA_BITS-1:0] data_sync = sync_stage[15:0];
    wire wide_mem_n_sync = sync_stage[16];
    wire wide_io_n_sync = sync_stage[17];
    wire sec_owns = (owner_in == isa_pkg::OWN_SECONDARY);
    wire sec_cycle_start = sec_owns && sec_prev[0] && !sync_stage[18];
    wire sec_refresh_start = sec_owns && sec_prev[1] && !sync_stage[19];

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    seq_state_e state;
    isa_pkg::cycle_kind_e kind;
    logic [isa_pkg::MEM_ADDR_BITS-1:0] addr;
    logic [isa_pkg::CNT_W-1:0] cnt;
    logic [isa_pkg::ROW_BITS-1:0] row;
    logic [isa_pkg::DATA_BITS-1:0] wdata;
    logic [isa_pkg::DATA_BITS-1:0] rdata;
    logic word;
    logic write;
    logic narrow;
    logic second;
    logic sec_pass;
    logic sec_ref;
    logic addr_oe;
    logic strobe;
    logic data_oe;
    logic [isa_pkg::DATA_BITS-1:0] dout;
    logic resp_valid;
    logic dma_address_enable;

    isa_steer_if st ();

    isa_byte_steer u_steer (
        .st(st.steer)
    );

    assign st.odd = addr[0];
    assign st.word = word;
    assign st.second = second;
    assign st.wdata = wdata;
    assign st.pin_din = data_sync;

    // ------------------------------------------------------------
    // request acceptance and sequencing events
    // ------------------------------------------------------------
    wire idle = (state == ST_IDLE);
    wire kind_allowed = (owner_in == isa_pkg::OWN_CPU) ? (req_kind_in != isa_pkg::KIND_DMA) :
                        (owner_in == isa_pkg::OWN_DMA) ? (req_kind_in == isa_pkg::KIND_DMA ||
                                                          req_kind_in == isa_pkg::KIND_REFRESH) : 1'b0;
    assign req_ready_out = idle && ce_in && kind_allowed;
    wire accept = req_valid_in && req_ready_out;
    wire start_sref = idle && sec_refresh_start; // [R05]
    wire start_spass = idle && sec_cycle_start && !sec_refresh_start;
    wire strobe_last = (state == ST_STROBE) && (cnt == '0);
    wire xfer_last = (state == ST_XFER) && (cnt == '0);
    wire split_next = xfer_last && word && narrow && !second; // [R21]
    wire enter_strobe = accept || start_sref || start_spass || split_next;
    wire enter_xfer = strobe_last && !sec_pass;
    wire finish = (xfer_last && !split_next) || (strobe_last && sec_pass);
    wire sampled_narrow = (kind == isa_pkg::KIND_IO) ? wide_io_n_sync :
                          (kind == isa_pkg::KIND_REFRESH) ? 1'b0 : wide_mem_n_sync;
    assign st.narrow = (strobe_last && !second) ? sampled_narrow : narrow; // [R20] [R21]

    seq_state_e next_state;
    assign next_state = enter_strobe ? ST_STROBE : (enter_xfer ? ST_XFER : (finish ? ST_IDLE : state));

    logic [isa_pkg::CNT_W-1:0] next_cnt;
    assign next_cnt = enter_strobe ? isa_pkg::CNT_W'(isa_pkg::STROBE_CLKS - 1) :
                      enter_xfer ? isa_pkg::CNT_W'(isa_pkg::XFER_CLKS - 1) :
                      (cnt != '0) ? cnt - 1'b1 : cnt;

    logic [isa_pkg::DATA_BITS-1:0] next_rdata;
    assign next_rdata = (word && !narrow) ? data_sync :
                        !word ? {st.rd_byte, st.rd_byte} :
                        second ? {st.rd_byte, rdata[7:0]} : {rdata[15:8], st.rd_byte};

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            cnt <= '0;
        end else if (ce_in) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            kind <= isa_pkg::KIND_MEM;
            addr <= '0;
            word <= 1'b0;
            write <= 1'b0;
            wdata <= '0;
            sec_ref <= 1'b0;
        end else if (ce_in) begin
            if (accept) begin
                kind <= req_kind_in;
                addr <= form_address(req_kind_in, req_addr_in, row);
                word <= req_word_in && (req_kind_in != isa_pkg::KIND_REFRESH);
                write <= req_write_in && (req_kind_in != isa_pkg::KIND_REFRESH);
                wdata <= req_wdata_in;
                sec_ref <= 1'b0;
            end else if (start_sref) begin
                kind <= isa_pkg::KIND_REFRESH;
                addr <= form_address(isa_pkg::KIND_REFRESH, '0, row); // [R05] [R08]
                word <= 1'b0;
                write <= 1'b0;
                sec_ref <= 1'b1;
            end else if (split_next) begin
                addr <= form_address(kind, addr | 24'h000001, row); // [R21]
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            second <= 1'b0;
            narrow <= 1'b0;
            sec_pass <= 1'b0;
        end else if (ce_in) begin
            if (accept || start_sref || start_spass) begin
                second <= 1'b0;
                narrow <= 1'b0;
                sec_pass <= start_spass;
            end else if (split_next) begin
                second <= 1'b1;
            end else if (strobe_last && !second) begin
                narrow <= sampled_narrow;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            strobe <= 1'b0;
            addr_oe <= 1'b0;
            dma_address_enable <= 1'b0;
        end else if (ce_in) begin
            // strobe for own, DMA, refresh and secondary cycles alike
            strobe <= enter_strobe || (strobe && !strobe_last); // [R06] [R10] [R13] [R15]
            addr_oe <= accept || start_sref || (addr_oe && !finish); // [R17]
            dma_address_enable <= (owner_in == isa_pkg::OWN_DMA); // [R16] [R18]
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            data_oe <= 1'b0;
            dout <= '0;
        end else if (ce_in) begin
            // never drives the data lanes in a refresh
            data_oe <= (enter_xfer && write && kind != isa_pkg::KIND_REFRESH) || (data_oe && !xfer_last); // [R22]
            if (enter_xfer) begin
                dout <= st.pin_dout; // [R20]
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata <= '0;
            resp_valid <= 1'b0;
            row <= isa_pkg::ROW_RESET;
        end else if (ce_in) begin
            resp_valid <= xfer_last && !split_next && !sec_ref;
            if (xfer_last && !write && kind != isa_pkg::KIND_REFRESH) begin
                rdata <= next_rdata;
            end
            if (xfer_last && kind == isa_pkg::KIND_REFRESH) begin
                row <= row + 1'b1; // [R05]
            end
        end
    end

    assign latched_address_out = addr[isa_pkg::LATCHED_BITS-1:0]; // [R06]
    assign latched_address_oe_out = addr_oe;
    assign unlatched_upper_address_out = addr[isa_pkg::MEM_ADDR_BITS-1:isa_pkg::UPPER_LSB]; // [R09]
    assign unlatched_upper_address_oe_out = addr_oe;
    assign address_latch_strobe_out = strobe;
    assign dma_address_enable_out = dma_address_enable;
    assign high_byte_enable_n_out = st.high_en_n | (kind == isa_pkg::KIND_REFRESH); // [R12]
    assign high_byte_enable_oe_out = addr_oe;
    assign data_out = dout;
    assign data_oe_out = data_oe;
    assign resp_valid_out = resp_valid;
    assign resp_rdata_out = rdata;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in || !ce_in);

    property p_agent_limit;
        1'b1 |-> (AGENT_SLOTS <= isa_pkg::MAX_FAR_AGENTS);
    endproperty
    a_agent_limit: assert property (p_agent_limit) else $error("too many far agents"); // [R03]

    property p_io_low_zero;
        (addr_oe && kind == isa_pkg::KIND_IO) |-> (latched_address_out[19:16] == 4'h0);
    endproperty
    a_io_low_zero: assert property (p_io_low_zero) else $error("io cycle drives latched 19:16"); // [R07]

    property p_io_upper_zero;
        (addr_oe && kind == isa_pkg::KIND_IO) |-> (unlatched_upper_address_out == 7'h00);
    endproperty
    a_io_upper_zero: assert property (p_io_upper_zero) else $error("io cycle drives upper address"); // [R09]

    property p_refresh_addr;
        (addr_oe && kind == isa_pkg::KIND_REFRESH) |->
            (latched_address_out[19:8] == 12'h000 && unlatched_upper_address_out == 7'h00 &&
             latched_address_out[7:0] == row);
    endproperty
    a_refresh_addr: assert property (p_refresh_addr) else $error("refresh address wrong"); // [R08]

    property p_refresh_float;
        (state != ST_IDLE && kind == isa_pkg::KIND_REFRESH) |-> !data_oe_out;
    endproperty
    a_refresh_float: assert property (p_refresh_float) else $error("data driven in refresh"); // [R22]

    property p_aen_follows;
        (owner_in == isa_pkg::OWN_DMA) |=> dma_address_enable_out;
    endproperty
    a_aen_follows: assert property (p_aen_follows) else $error("dma enable missing"); // [R16]

    property p_aen_off;
        (owner_in != isa_pkg::OWN_DMA) |=> !dma_address_enable_out;
    endproperty
    a_aen_off: assert property (p_aen_off) else $error("dma enable while not dma owner"); // [R16]

    property p_strobe_width;
        $rose(address_latch_strobe_out) |-> address_latch_strobe_out [*3];
    endproperty
    a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // [R13]

    property p_dma_strobe;
        (accept && req_kind_in == isa_pkg::KIND_DMA) |=> (address_latch_strobe_out && latched_address_oe_out);
    endproperty
    a_dma_strobe: assert property (p_dma_strobe) else $error("dma cycle without strobe"); // [R15]

    property p_split;
        split_next |=> (state == ST_STROBE && second && latched_address_out[0] && address_latch_strobe_out);
    endproperty
    a_split: assert property (p_split) else $error("narrow word not split"); // [R21]

    property p_word_high;
        (state == ST_XFER && word && !narrow) |-> !high_byte_enable_n_out;
    endproperty
    a_word_high: assert property (p_word_high) else $error("high byte enable missing"); // [R12]

    property p_odd_copy;
        (data_oe_out && narrow && (addr[0] || second)) |-> (data_out[15:8] == data_out[7:0]);
    endproperty
    a_odd_copy: assert property (p_odd_copy) else $error("odd byte not copied high"); // [R20]

    property p_sec_refresh;
        start_sref |=> (kind == isa_pkg::KIND_REFRESH && address_latch_strobe_out && latched_address_oe_out);
    endproperty
    a_sec_refresh: assert property (p_sec_refresh) else $error("secondary refresh not run"); // [R05]

    property p_sec_strobe;
        start_spass |=> (address_latch_strobe_out && !latched_address_oe_out) [*3];
    endproperty
    a_sec_strobe: assert property (p_sec_strobe) else $error("secondary cycle strobe wrong"); // [R10]

    c_split: cover property (split_next);
    c_sec_refresh: cover property (start_sref);
    c_dma: cover property (accept && req_kind_in == isa_pkg::KIND_DMA);
    c_narrow_odd: cover property (data_oe_out && narrow && addr[0]);

endmodule // isa_primary_agent

// File: dv/isa_far_agent.sv
// far-side replier: answers reads from an address hash, 8 or 16 bits wide
`timescale 1ns/10ps
module isa_far_agent (
    // clock
    input wire logic core_clk_in,
    // slot pins: reads the address group, drives only data and width selects
    input wire logic [19:0] latched_address_in,
    input wire logic latched_address_oe_in,
    input wire logic data_oe_in,
    output logic [15:0] data_out,
    output logic wide_memory_select_n_out,
    output logic wide_io_select_n_out
);
    logic [15:0] junk = 16'h3C5A;
    logic [7:0] base;
    logic narrow, answering;
    // --------
    // replier
    // --------
    // undriven lanes show a pattern that moves every cycle
    always @(posedge core_clk_in) junk <= ~{junk[14:0], junk[15]};
    assign narrow = latched_address_in[12];
    assign wide_memory_select_n_out = narrow | ~latched_address_oe_in;
    assign wide_io_select_n_out = narrow | ~latched_address_oe_in;
    // answers only a cycle the requester started, while its address stands
    assign answering = latched_address_oe_in & ~data_oe_in;
    assign base = latched_address_in[7:0] ^ latched_address_in[15:8] ^ 8'hA5;
    // a narrow board sits on the low lanes only
    assign data_out = !answering ? junk : narrow ? {junk[15:8], base}
        : {base ^ {7'h00, ~latched_address_in[0]}, base ^ {7'h00, latched_address_in[0]}};
endmodule // isa_far_agent

// File: dv/isa_primary_agent_address_data_tb.sv
// self-checking bench for the primary requester address and data path
`timescale 1ns/10ps
module isa_primary_agent_address_data_tb;
    // --------
    // pins
    // --------
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce_in = 1'b1;
    logic req_valid_in = 1'b0, req_word_in = 1'b0, req_write_in = 1'b0;
    logic secondary_cycle_n_in = 1'b1, secondary_refresh_n_in = 1'b1;
    isa_pkg::cycle_kind_e req_kind_in = isa_pkg::KIND_MEM;
    isa_pkg::bus_owner_e owner_in = isa_pkg::OWN_CPU;
    logic [23:0] req_addr_in = 24'h000000;
    logic [15:0] req_wdata_in = 16'h0000;
    logic req_ready_out, resp_valid_out, latched_address_oe_out, unlatched_upper_address_oe_out;
    logic address_latch_strobe_out, dma_address_enable_out, high_byte_enable_n_out, high_byte_enable_oe_out;
    logic data_oe_out, wide_memory_select_n_in, wide_io_select_n_in;
    logic [15:0] resp_rdata_out, data_in, data_out, far_data;
    logic [19:0] latched_address_out;
    logic [6:0] unlatched_upper_address_out;
    int miscompares = 0, n_compared = 0;
    logic [7:0] row = 8'h00;

    always #50 core_clk_in = ~core_clk_in;
    // requester wins the data wire while it drives
    assign data_in = data_oe_out ? data_out : far_data;

    isa_primary_agent #(.AGENT_SLOTS(4)) dut_u (
        .core_clk_in, .ce_in, .reset_in, .req_valid_in, .req_ready_out, .req_kind_in, .req_addr_in,
        .req_word_in, .req_write_in, .req_wdata_in, .resp_valid_out, .resp_rdata_out, .owner_in,
        .latched_address_out, .latched_address_oe_out, .unlatched_upper_address_out,
        .unlatched_upper_address_oe_out, .address_latch_strobe_out, .dma_address_enable_out,
        .high_byte_enable_n_out, .high_byte_enable_oe_out, .data_in, .data_out, .data_oe_out,
        .wide_memory_select_n_in, .wide_io_select_n_in, .secondary_cycle_n_in, .secondary_refresh_n_in);

    isa_far_agent far_u (.core_clk_in, .latched_address_in(latched_address_out),
        .latched_address_oe_in(latched_address_oe_out), .data_oe_in(data_oe_out), .data_out(far_data),
        .wide_memory_select_n_out(wide_memory_select_n_in), .wide_io_select_n_out(wide_io_select_n_in));

    // --------
    // helpers
    // --------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [7:0] bh(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction

    task automatic wait_strobe;
        int n;
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (address_latch_strobe_out !== 1'b1 && n < 30);
    endtask

    // one local request, checked in mid-transfer and at its end
    task automatic run_op(input isa_pkg::cycle_kind_e k, input logic [23:0] a, input logic w, wr,
                          input logic [15:0] wd);
        int t;
        logic nar, rf, io, h, odd;
        logic [23:0] aa;
        logic [31:0] strb;
        logic [15:0] m;
        logic [7:0] b;
        rf = k == isa_pkg::KIND_REFRESH;
        io = k == isa_pkg::KIND_IO;
        nar = a[12] & ~rf;
        strb = 32'h0;
        t = 0;
        @(posedge core_clk_in);
        owner_in <= k == isa_pkg::KIND_DMA ? isa_pkg::OWN_DMA : isa_pkg::OWN_CPU;
        req_kind_in <= k;
        req_addr_in <= a;
        req_word_in <= w;
        req_write_in <= wr;
        req_wdata_in <= wd;
        req_valid_in <= 1'b1;
        @(negedge core_clk_in);
        while (req_ready_out !== 1'b1 && t < 50) begin
            @(negedge core_clk_in);
            t++;
        end
        @(posedge core_clk_in);
        req_valid_in <= 1'b0;
        t = 0;
        do begin
            @(negedge core_clk_in);
            t++;
            strb[t] = address_latch_strobe_out;
            if (t == 5 || (nar && w && t == 13)) begin
                h = t == 13;
                aa = a | {23'h0, h};
                odd = w ? h : aa[0];
                b = odd ? wd[15:8] : wd[7:0];
                m = w && !nar ? 16'hFFFF : odd ? (nar ? 16'hFFFF : 16'hFF00) : 16'h00FF;
                check(24'(latched_address_out), rf ? {16'h0, row} : io ? {8'h0, aa[15:0]} : {4'h0, aa[19:0]});
                check(24'(unlatched_upper_address_out), rf || io ? 24'h0 : 24'(aa[23:17]));
                check({19'h0, unlatched_upper_address_oe_out, high_byte_enable_oe_out, latched_address_oe_out,
                       high_byte_enable_n_out, data_oe_out},
                      {21'h7, rf | (w ? nar & !h : !aa[0]), wr & !rf});
                check(24'(dma_address_enable_out), 24'(k == isa_pkg::KIND_DMA));
                if (wr && !rf) check(24'(data_out & m), 24'((w && !nar ? wd : {b, b}) & m));
            end
        end while (resp_valid_out !== 1'b1 && t < 30);
        check(24'(t), w && nar ? 24'd17 : 24'd9);
        check(24'(strb[17:1]), w && nar ? 24'h000707 : 24'h000007);
        if (!wr && !rf) check(24'(resp_rdata_out), 24'(w ? {bh(a | 24'h1), bh(a & ~24'h1)} : {bh(a), bh(a)}));
        if (rf) row++;
    endtask

    // --------
    // tests
    // --------
    initial begin
        isa_pkg::cycle_kind_e k;
        logic [23:0] a;
        logic w;
        void'($urandom(61397));
        repeat (4) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(negedge core_clk_in);
        check({19'h0, address_latch_strobe_out, latched_address_oe_out, data_oe_out,
               dma_address_enable_out, high_byte_enable_n_out}, 24'h000001);
        run_op(isa_pkg::KIND_REFRESH, 24'hFFFFFF, 1'b1, 1'b1, 16'hFFFF);
        run_op(isa_pkg::KIND_IO, 24'hFFFFFF, 1'b0, 1'b0, 16'h0000);
        run_op(isa_pkg::KIND_MEM, 24'hFEFFFE, 1'b1, 1'b1, 16'hA55A);
        run_op(isa_pkg::KIND_MEM, 24'h801001, 1'b0, 1'b1, 16'hC33C);
        run_op(isa_pkg::KIND_DMA, 24'hABC000, 1'b1, 1'b0, 16'h0000);
        repeat (30) begin
            k = isa_pkg::cycle_kind_e'($urandom_range(3));
            a = 24'($urandom);
            w = 1'($urandom_range(1));
            run_op(k, a & ~{23'h0, w}, w, 1'($urandom_range(1)), 16'($urandom));
        end
        // a 16-bit secondary owns the bus, asks for refresh, then runs a cycle
        @(posedge core_clk_in);
        owner_in <= isa_pkg::OWN_SECONDARY;
        secondary_refresh_n_in <= 1'b0;
        repeat (2) @(negedge core_clk_in);
        check({22'h0, req_ready_out, dma_address_enable_out}, 24'h0);
        wait_strobe();
        check(24'(latched_address_out), {16'h0, row});
        check({16'h0, unlatched_upper_address_out, latched_address_oe_out}, 24'h1);
        row++;
        repeat (14) @(posedge core_clk_in);
        secondary_refresh_n_in <= 1'b1;
        secondary_cycle_n_in <= 1'b0;
        wait_strobe();
        a = 24'h0;
        while (address_latch_strobe_out === 1'b1 && a < 24'd10) begin
            check(24'(latched_address_oe_out), 24'h0);
            a++;
            @(negedge core_clk_in);
        end
        check(a, 24'd3);
        @(posedge core_clk_in);
        secondary_cycle_n_in <= 1'b1;
        tally_and_finish();
    end

    // watchdog
    initial begin
        #(100 * 8000);
        miscompares++;
        tally_and_finish();
    end
endmodule // isa_primary_agent_address_data_tb
